// ### adc_clock_timing_resolution_ctrl.sv
// Purpose: converter clock gating, conversion clock and resolution control, AXI4-Lite registers
// Assumes: single clock core_clk; AXI master keeps valid and payload steady until ready
// Notes: only byte lane 0 carries register data; upper bits read as zero
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_clock_timing_resolution_ctrl #(
	parameter int CLK_HZ = 25000000
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic adc_clk_en,
	output logic timer_clk_en,
	output logic fad_tick,
	output logic sampling,
	output logic conv_busy,
	output logic conv_done,
	output logic resolution_8bit
);
	localparam logic FAST_CLK = (CLK_HZ >= `PROHIB_LIMIT_HZ);

	logic [7:0] peripheral_clock_gate;
	logic [7:0] converter_mode_primary;
	logic [7:0] converter_resolution_cfg;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_lane0;
	logic aw_full;
	logic w_full;
	logic wr_fire;
	logic wr_mapped;
	logic rd_mapped;
	logic sel_prohibited;
	logic [7:0] status_val;
	logic [7:0] rd_val;

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	assign wr_fire = aw_full && w_full && !s_axi_bvalid;
	assign wr_mapped = (wr_addr == `OFS_PERIPH_GATE) || (wr_addr == `OFS_MODE_PRIMARY)
		|| (wr_addr == `OFS_RES_CFG) || (wr_addr == `OFS_STATUS);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			aw_full <= 1'b0;
			wr_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_full <= 1'b1;
			wr_addr <= {s_axi_awaddr[7:2], 2'b00};
		end else if (wr_fire)
			aw_full <= 1'b0;
		else if (!aw_full && !s_axi_bvalid)
			s_axi_awready <= 1'b1;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_wready <= 1'b0;
			w_full <= 1'b0;
			wr_data <= 8'h00;
			wr_lane0 <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_full <= 1'b1;
			wr_data <= s_axi_wdata[7:0];
			wr_lane0 <= s_axi_wstrb[0];
		end else if (wr_fire)
			w_full <= 1'b0;
		else if (!w_full && !s_axi_bvalid)
			s_axi_wready <= 1'b1;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ****************************************
	// configuration registers
	// ****************************************
	// status is read-only; a write there is accepted and dropped
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			peripheral_clock_gate <= `RST_PERIPH_GATE;
			converter_mode_primary <= `RST_MODE_PRIMARY;
			converter_resolution_cfg <= `RST_RES_CFG;
		end else if (wr_fire && wr_lane0) begin
			if (wr_addr == `OFS_PERIPH_GATE)
				peripheral_clock_gate <= wr_data & `MASK_PERIPH_GATE;
			if (wr_addr == `OFS_MODE_PRIMARY)
				converter_mode_primary <= wr_data & `MASK_MODE_PRIMARY;
			if (wr_addr == `OFS_RES_CFG)
				converter_resolution_cfg <= wr_data & `MASK_RES_CFG;
		end
	end

	// ****************************************
	// clock gates and mode outputs
	// ****************************************
	// both gate bits must be set; either alone holds the sequencer in idle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			adc_clk_en <= 1'b0;
		else
			adc_clk_en <= peripheral_clock_gate[`BIT_CONV_GATE]
				&& converter_mode_primary[`BIT_LOCAL_CLK_EN];
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			timer_clk_en <= 1'b0;
		else
			timer_clk_en <= peripheral_clock_gate[`BIT_TIMER_GATE];
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			resolution_8bit <= 1'b0;
		else
			resolution_8bit <= converter_resolution_cfg[`BIT_RES_SEL];
	end

	// flags a divider choice software must not use at this system clock
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			sel_prohibited <= 1'b0;
		else
			sel_prohibited <= FAST_CLK
				? (converter_mode_primary[`BIT_SEL_HI:`BIT_SEL_LO] == 2'b11)
				: (converter_mode_primary[`BIT_SEL_HI:`BIT_SEL_LO] == 2'b00);
	end

	conv_sequencer u_seq (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.run(converter_mode_primary[`BIT_RUN_CTRL]),
		.clk_on(adc_clk_en),
		.div_sel(converter_mode_primary[`BIT_SEL_HI:`BIT_SEL_LO]),
		.lv_sel(converter_mode_primary[`BIT_LOW_VOLT]),
		.res_8bit(converter_resolution_cfg[`BIT_RES_SEL]),
		.fad_tick(fad_tick),
		.sampling(sampling),
		.busy(conv_busy),
		.conv_done(conv_done)
	);

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	assign status_val = {4'h0, sel_prohibited, adc_clk_en, sampling, conv_busy};
	assign rd_mapped = (s_axi_araddr[7:2] == `OFS_PERIPH_GATE >> 2)
		|| (s_axi_araddr[7:2] == `OFS_MODE_PRIMARY >> 2)
		|| (s_axi_araddr[7:2] == `OFS_RES_CFG >> 2)
		|| (s_axi_araddr[7:2] == `OFS_STATUS >> 2);

	always_comb begin
		unique case ({s_axi_araddr[7:2], 2'b00})
			`OFS_PERIPH_GATE: rd_val = peripheral_clock_gate;
			`OFS_MODE_PRIMARY: rd_val = converter_mode_primary;
			`OFS_RES_CFG: rd_val = converter_resolution_cfg;
			`OFS_STATUS: rd_val = status_val;
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_val};
			s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_conv_gate_on: assert property (wr_fire && wr_lane0 && wr_addr == `OFS_PERIPH_GATE
		&& wr_data[`BIT_CONV_GATE] && converter_mode_primary[`BIT_LOCAL_CLK_EN]
		|=> ##1 adc_clk_en)
		else $error("converter clock not supplied after gate set");
	a_conv_gate_off: assert property (!peripheral_clock_gate[`BIT_CONV_GATE]
		|=> !adc_clk_en ##2 !conv_busy)
		else $error("converter kept running with gate clear");
	a_local_gate: assert property ($fell(converter_mode_primary[`BIT_LOCAL_CLK_EN])
		|-> ##1 !adc_clk_en ##2 !conv_busy && !fad_tick)
		else $error("local enable clear did not stop converter clock");
	a_timer_gate: assert property ($changed(peripheral_clock_gate[`BIT_TIMER_GATE])
		|=> timer_clk_en == $past(peripheral_clock_gate[`BIT_TIMER_GATE]))
		else $error("timer clock gate does not follow its bit");
	a_res_select: assert property (wr_fire && wr_lane0 && wr_addr == `OFS_RES_CFG
		|=> ##1 resolution_8bit == $past(wr_data[`BIT_RES_SEL], 2))
		else $error("resolution output does not follow its bit");

	c_write_done: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `RESP_OKAY);
	c_read_slverr: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule // adc_clock_timing_resolution_ctrl

// ### adc_ctrl_pkg.sv
// Purpose: shared types of the converter control
// Assumes: nothing
// Notes: constants live in adc_ctrl_regs.svh
package adc_ctrl_pkg;
	typedef enum logic [1:0] {
		seq_idle,
		seq_sample,
		seq_convert
	} seq_state_type;
endpackage

// ### adc_ctrl_regs.svh
// Purpose: register map, field positions and conversion counts of the converter control
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes: definitions only
//
// Overview of operation
// - converter clock-gate bit of peripheral gate register supplies converter clock when 1.
// - timer-unit clock-gate bit 0 supplies timer unit clock when 1.
// - local clock enable bit 0 of mode register also gates converter clock.
// - clock select 00/01/10/11 divides system clock by 8/4/2/1.
// - 10-bit conversion takes 23 clocks (9 sampling), or 17 (5) in low voltage.
// - 8-bit conversion takes 21 clocks (9 sampling), or 15 (3) in low voltage.
// - resolution select bit 0 picks 10-bit results at 0, 8-bit at 1.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_PERIPH_GATE 8'h00
`define OFS_MODE_PRIMARY 8'h04
`define OFS_RES_CFG 8'h08
`define OFS_STATUS 8'h0c

// ****************************************
// fields, masks, reset values
// ****************************************
`define BIT_TIMER_GATE 0
`define BIT_CONV_GATE 5
`define BIT_LOCAL_CLK_EN 0
`define BIT_LOW_VOLT 1
`define BIT_SEL_LO 3
`define BIT_SEL_HI 4
`define BIT_RUN_CTRL 7
`define BIT_RES_SEL 0
`define MASK_PERIPH_GATE 8'hf5
`define MASK_MODE_PRIMARY 8'h9b
`define MASK_RES_CFG 8'h01
`define RST_PERIPH_GATE 8'h00
`define RST_MODE_PRIMARY 8'h00
`define RST_RES_CFG 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************
// divider and conversion counts
// ****************************************
`define DIV8_LAST 3'h7
`define DIV4_LAST 3'h3
`define DIV2_LAST 3'h1
`define DIV1_LAST 3'h0
`define TOTAL_10_STD 5'h17
`define SAMP_10_STD 5'h09
`define TOTAL_10_LV 5'h11
`define SAMP_10_LV 5'h05
`define TOTAL_8_STD 5'h15
`define SAMP_8_STD 5'h09
`define TOTAL_8_LV 5'h0f
`define SAMP_8_LV 5'h03
`define PROHIB_LIMIT_HZ 10000000

`endif

// ### conv_sequencer.sv
// Purpose: conversion clock divider and sampling/conversion sequence
// Assumes: settings stay put while idle; they are frozen for a running conversion
// Notes: all outputs registered, one cycle after the internal event
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module conv_sequencer (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic run,
	input wire logic clk_on,
	input wire logic [1:0] div_sel,
	input wire logic lv_sel,
	input wire logic res_8bit,
	output logic fad_tick,
	output logic sampling,
	output logic busy,
	output logic conv_done
);
	adc_ctrl_pkg::seq_state_type state;
	logic [1:0] div_l;
	logic lv_l;
	logic res_l;
	logic [2:0] div_cnt;
	logic [2:0] div_last;
	logic [4:0] phase_left;
	logic [4:0] tick_seen;
	logic tick_now;
	logic last_tick;

	function automatic logic [4:0] samp_of(input logic res, input logic lv);
		if (res)
			return lv ? `SAMP_8_LV : `SAMP_8_STD;
		return lv ? `SAMP_10_LV : `SAMP_10_STD;
	endfunction

	function automatic logic [4:0] total_of(input logic res, input logic lv);
		if (res)
			return lv ? `TOTAL_8_LV : `TOTAL_8_STD;
		return lv ? `TOTAL_10_LV : `TOTAL_10_STD;
	endfunction

	// ****************************************
	// conversion clock divider
	// ****************************************
	always_comb begin
		unique case (div_l)
			2'b00: div_last = `DIV8_LAST;
			2'b01: div_last = `DIV4_LAST;
			2'b10: div_last = `DIV2_LAST;
			2'b11: div_last = `DIV1_LAST;
		endcase
	end

	assign tick_now = clk_on && (state != adc_ctrl_pkg::seq_idle) && (div_cnt == div_last);
	assign last_tick = tick_now && (phase_left == 5'h00);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			div_cnt <= 3'h0;
		else if (state == adc_ctrl_pkg::seq_idle || tick_now)
			div_cnt <= 3'h0;
		else
			div_cnt <= div_cnt + 3'h1;
	end

	// settings frozen per conversion so a mid-conversion write cannot skew the count
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_l <= 2'b00;
			lv_l <= 1'b0;
			res_l <= 1'b0;
		end else if (state == adc_ctrl_pkg::seq_idle) begin
			div_l <= div_sel;
			lv_l <= lv_sel;
			res_l <= res_8bit;
		end
	end

	// ****************************************
	// sampling and conversion phases
	// ****************************************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			state <= adc_ctrl_pkg::seq_idle;
		else if (!clk_on)
			state <= adc_ctrl_pkg::seq_idle;
		else begin
			unique case (state)
				adc_ctrl_pkg::seq_idle: if (run) state <= adc_ctrl_pkg::seq_sample;
				adc_ctrl_pkg::seq_sample: if (last_tick) state <= adc_ctrl_pkg::seq_convert;
				adc_ctrl_pkg::seq_convert: if (last_tick) state <= adc_ctrl_pkg::seq_idle;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			phase_left <= 5'h00;
		else if (state == adc_ctrl_pkg::seq_idle)
			phase_left <= samp_of(res_8bit, lv_sel) - 5'h01;
		else if (last_tick)
			phase_left <= total_of(res_l, lv_l) - samp_of(res_l, lv_l) - 5'h01;
		else if (tick_now)
			phase_left <= phase_left - 5'h01;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fad_tick <= 1'b0;
			sampling <= 1'b0;
			busy <= 1'b0;
			conv_done <= 1'b0;
		end else begin
			fad_tick <= tick_now;
			sampling <= clk_on && state == adc_ctrl_pkg::seq_sample;
			busy <= clk_on && state != adc_ctrl_pkg::seq_idle;
			conv_done <= last_tick && state == adc_ctrl_pkg::seq_convert;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			tick_seen <= 5'h00;
		else if (state == adc_ctrl_pkg::seq_idle)
			tick_seen <= 5'h00;
		else if (tick_now)
			tick_seen <= tick_seen + 5'h01;
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_div_by_eight: assert property (tick_now && div_l == 2'b00 |=> !tick_now [*7])
		else $error("divide by 8 tick came early");
	a_div_by_two: assert property (tick_now && div_l == 2'b10 && !last_tick
		|=> !tick_now ##1 (tick_now || state == adc_ctrl_pkg::seq_idle))
		else $error("divide by 2 tick spacing wrong");
	a_conv_ten_bit: assert property (last_tick && state == adc_ctrl_pkg::seq_convert && !res_l
		|-> tick_seen + 5'h01 == (lv_l ? `TOTAL_10_LV : `TOTAL_10_STD))
		else $error("10-bit conversion length wrong");
	a_conv_eight_bit: assert property (last_tick && state == adc_ctrl_pkg::seq_convert && res_l
		|-> tick_seen + 5'h01 == (lv_l ? `TOTAL_8_LV : `TOTAL_8_STD))
		else $error("8-bit conversion length wrong");
	a_sample_len: assert property (last_tick && state == adc_ctrl_pkg::seq_sample
		|-> tick_seen + 5'h01 == samp_of(res_l, lv_l) ##1 sampling ##1 !sampling)
		else $error("sampling length wrong");

	c_eight_lv_done: cover property (last_tick && state == adc_ctrl_pkg::seq_convert && res_l && lv_l);
	c_ten_std_done: cover property (last_tick && state == adc_ctrl_pkg::seq_convert && !res_l && !lv_l);
endmodule // conv_sequencer

// ### tb_adc_clock_timing_resolution_ctrl.sv
// Purpose: self-checking bench of the converter clock, timing and resolution control
// Assumes: AXI4-Lite slave timing as handed over; 25 MHz core clock
// Notes: outputs are looked at on the falling edge, inputs change after the rising edge
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module tb_adc_clock_timing_resolution_ctrl;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic adc_clk_en, timer_clk_en, fad_tick, sampling, conv_busy, conv_done, resolution_8bit;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int bc, sc, gap, dc, tot, smp, div;

	adc_clock_timing_resolution_ctrl #(.CLK_HZ(25000000)) i_adc_clock_timing_resolution_ctrl (
		.core_clk(core_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .adc_clk_en(adc_clk_en), .timer_clk_en(timer_clk_en),
		.fad_tick(fad_tick), .sampling(sampling), .conv_busy(conv_busy),
		.conv_done(conv_done), .resolution_8bit(resolution_8bit)
	);

	// ****************************************
	// clock and hang guard
	// ****************************************
	initial begin
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		// whole run needs about 3000 cycles
		if (cyc == 20000) begin
			error_cnt++;
			$display("mismatch timeout expected end seen cycle %0d", cyc);
			end_sim();
		end
	end

	// ****************************************
	// compare, bus and measuring tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic [1:0] exp);
		int n;
		logic aw_p, w_p, aw_h, w_h, b_h;
		logic [1:0] resp;
		@(posedge core_clk);
		awaddr <= addr;
		wdata <= {24'h0, data};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_p = 1'b1;
		w_p = 1'b1;
		b_h = 1'b0;
		resp = 2'h3;
		n = 0;
		while (!b_h && n < 100) begin
			@(negedge core_clk);
			aw_h = aw_p && (awready === 1'b1);
			w_h = w_p && (wready === 1'b1);
			b_h = !aw_p && !w_p && (bvalid === 1'b1);
			if (b_h)
				resp = bresp;
			@(posedge core_clk);
			if (aw_h) begin
				awvalid <= 1'b0;
				aw_p = 1'b0;
			end
			if (w_h) begin
				wvalid <= 1'b0;
				w_p = 1'b0;
			end
			if (b_h)
				bready <= 1'b0;
			n++;
		end
		chk("write response", {30'h0, exp}, {30'h0, resp});
	endtask

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] exp_r);
		int n;
		logic ar_p, r_h;
		logic [31:0] data;
		logic [1:0] resp;
		@(posedge core_clk);
		araddr <= addr;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ar_p = 1'b1;
		r_h = 1'b0;
		data = 32'hffffffff;
		resp = 2'h3;
		n = 0;
		while (!r_h && n < 100) begin
			@(negedge core_clk);
			r_h = !ar_p && (rvalid === 1'b1);
			if (r_h) begin
				data = rdata;
				resp = rresp;
			end
			if (ar_p && arready === 1'b1) begin
				@(posedge core_clk);
				arvalid <= 1'b0;
				ar_p = 1'b0;
			end else begin
				@(posedge core_clk);
			end
			if (r_h)
				rready <= 1'b0;
			n++;
		end
		chk("read data", exp, data);
		chk("read response", {30'h0, exp_r}, {30'h0, resp});
	endtask

	task automatic settle;
		repeat (2) @(negedge core_clk);
	endtask

	// counts one conversion: busy length, sampling length, tick spacing, done pulses
	task automatic measure;
		int n, last;
		bc = 0;
		sc = 0;
		gap = -1;
		dc = 0;
		last = -1;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (conv_busy !== 1'b1 && n < 50);
		while (conv_busy === 1'b1 && bc < 400) begin
			if (sampling === 1'b1)
				sc++;
			if (conv_done === 1'b1)
				dc++;
			if (fad_tick === 1'b1) begin
				if (last >= 0 && gap < 0)
					gap = bc - last;
				last = bc;
			end
			bc++;
			@(negedge core_clk);
		end
		// done lands in the last busy cycle, never in the idle cycle after busy falls
		if (conv_done === 1'b1)
			dc++;
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(`OFS_PERIPH_GATE, 32'h0, `RESP_OKAY);
		rd(`OFS_MODE_PRIMARY, 32'h0, `RESP_OKAY);
		rd(`OFS_RES_CFG, 32'h0, `RESP_OKAY);
		rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
		chk("timer_clk_en", 32'h0, {31'h0, timer_clk_en});
		chk("adc_clk_en", 32'h0, {31'h0, adc_clk_en});
		wr(`OFS_PERIPH_GATE, 8'hff, `RESP_OKAY);
		rd(`OFS_PERIPH_GATE, 32'hf5, `RESP_OKAY);
		settle();
		chk("timer_clk_en", 32'h1, {31'h0, timer_clk_en});
		chk("adc_clk_en", 32'h0, {31'h0, adc_clk_en});
		wr(`OFS_RES_CFG, 8'hff, `RESP_OKAY);
		rd(`OFS_RES_CFG, 32'h01, `RESP_OKAY);
		settle();
		chk("resolution_8bit", 32'h1, {31'h0, resolution_8bit});
		wr(`OFS_RES_CFG, 8'h00, `RESP_OKAY);
		settle();
		chk("resolution_8bit", 32'h0, {31'h0, resolution_8bit});
		wr(8'h10, 8'h5a, `RESP_SLVERR);
		rd(8'h10, 32'h0, `RESP_SLVERR);
		$display("test registers done");

		wr(`OFS_MODE_PRIMARY, 8'h01, `RESP_OKAY);
		settle();
		chk("adc_clk_en", 32'h1, {31'h0, adc_clk_en});
		rd(`OFS_STATUS, 32'h04, `RESP_OKAY);
		wr(`OFS_PERIPH_GATE, 8'hdf, `RESP_OKAY);
		settle();
		chk("adc_clk_en", 32'h0, {31'h0, adc_clk_en});
		chk("timer_clk_en", 32'h1, {31'h0, timer_clk_en});
		wr(`OFS_PERIPH_GATE, 8'h20, `RESP_OKAY);
		settle();
		chk("timer_clk_en", 32'h0, {31'h0, timer_clk_en});
		chk("adc_clk_en", 32'h1, {31'h0, adc_clk_en});
		wr(`OFS_MODE_PRIMARY, 8'h00, `RESP_OKAY);
		settle();
		chk("adc_clk_en", 32'h0, {31'h0, adc_clk_en});
		$display("test clock gates done");

		for (int r = 0; r < 2; r++) begin
			for (int lv = 0; lv < 2; lv++) begin
				for (int sel = 0; sel < 4; sel++) begin
					div = 8 >> sel;
					tot = (r == 1) ? ((lv == 1) ? 15 : 21) : ((lv == 1) ? 17 : 23);
					smp = (r == 1) ? ((lv == 1) ? 3 : 9) : ((lv == 1) ? 5 : 9);
					wr(`OFS_RES_CFG, 8'(r), `RESP_OKAY);
					wr(`OFS_PERIPH_GATE, 8'h20, `RESP_OKAY);
					wr(`OFS_MODE_PRIMARY, 8'(8'h81 | (sel << 3) | (lv << 1)), `RESP_OKAY);
					measure();
					chk("busy cycles", tot * div, bc);
					chk("sampling cycles", smp * div, sc);
					chk("tick spacing", div, gap);
					chk("done pulses", 32'h1, dc);
					chk("resolution_8bit", r, {31'h0, resolution_8bit});
					// abort in mid-conversion, by the peripheral gate at select 3, else by the mode register
					measure();
					if (sel == 3)
						wr(`OFS_PERIPH_GATE, 8'h00, `RESP_OKAY);
					else
						wr(`OFS_MODE_PRIMARY, 8'h00, `RESP_OKAY);
					repeat (3) @(negedge core_clk);
					chk("adc_clk_en", 32'h0, {31'h0, adc_clk_en});
					chk("conv_busy", 32'h0, {31'h0, conv_busy});
					wr(`OFS_MODE_PRIMARY, 8'h00, `RESP_OKAY);
				end
			end
		end
		$display("test conversion timing done");
		// software keeps to the allowed selects; status shows the forbidden one at this clock
		wr(`OFS_MODE_PRIMARY, 8'h18, `RESP_OKAY);
		rd(`OFS_STATUS, 32'h08, `RESP_OKAY);
		wr(`OFS_MODE_PRIMARY, 8'h08, `RESP_OKAY);
		rd(`OFS_STATUS, 32'h00, `RESP_OKAY);
		$display("test prohibited select done");
		end_sim();
	end
endmodule // tb_adc_clock_timing_resolution_ctrl
